// [amsf_status.sv]
`timescale 1ns/1ps
// Summary of operation
// - set overrun flag when motion processing time exceeds the operation cycle
// - overrun flag holds until power cycle, system reset or program reset
// - one speed-change-accepting flag per axis, 8, 16 or 32 axes by variant, during a speed change
// - auto-decel flag high during automatic decel in positioning or follow-up
// - follow-up: flag high decelerating to command address, cleared on address change
// - constant-speed: flag high from decel start after the final point
// - auto-decel flag cleared once all normal start completion conditions are met
// - auto-decel flag may be high while still accelerating under advanced s-curve
// - auto-decel not cleared on jog release, pulse generator, stop decel, zero travel
// - zero-speed flag set when zero or negative speed change is accepted while started
// - zero-speed flag cleared by later speed change or stop-cause stop completion
// - during interpolation every interpolating axis gets its zero-speed flag
// - zero-speed request ignored after jog, stop-cause or auto-positioning decel
// - zero-speed flag cleared by new speed change during the zero-speed stop
// - zero-speed flag cleared when a stop cause follows the zero-speed accept
// - zero-speed request after decel toward follow-up address still sets the flag
// - follow-up address change during zero-speed hold does not restart the axis
// - stopped axis with start-accept held shows hold through zero-speed flag
// - loop-monitor flag high in fully closed loop, follows loop-change command
module amsf_status
  import amsf_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // configuration
  input wire logic [1:0] variant_sel,
  input wire logic [AMSF_TIME_W-1:0] operation_cycle_setting,
  input wire logic user_reset,
  // motion processing timing (same clock domain)
  input wire logic motion_start,
  input wire logic motion_done,
  // per-axis motion events, same clock domain, held until the next cycle tick
  input wire logic [31:0] start_accept_flags,
  input wire logic [31:0] speed_change_req,
  input wire logic [31:0] speed_change_zero,
  input wire logic [31:0] speed_change_done,
  input wire logic [31:0] interp_axes,
  input wire logic [31:0] auto_decel_active,
  input wire logic [31:0] followup_mode,
  input wire logic [31:0] followup_addr_change,
  input wire logic [31:0] start_complete,
  input wire logic [31:0] jog_decel,
  input wire logic [31:0] mpg_active,
  input wire logic [31:0] stop_decel,
  input wire logic [31:0] stop_cause,
  input wire logic [31:0] stop_complete,
  input wire logic [31:0] zero_travel,
  input wire logic [31:0] loop_change_cmd,
  // status flags
  output logic cycle_overrun_flag,
  output logic [31:0] speed_change_accepting_flags,
  output logic [31:0] auto_decelerating_flags,
  output logic [31:0] zero_speed_accepting_flags,
  output logic [31:0] loop_monitor_flags,
  output logic [31:0] restart_block
);

  // ****************************************
  // axis mask for the device variant
  // ****************************************
  function automatic logic [31:0] axis_mask(input logic [1:0] v);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < AMSF_AXES_MAX; i++) begin
      if (v == AMSF_VAR_8) begin
        m[i] = (i < AMSF_AXES_MIN);
      end else if (v == AMSF_VAR_16) begin
        m[i] = (i < AMSF_AXES_MID);
      end else begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  logic tick;
  logic [31:0] mask;

  amsf_tick u_tick (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .tick(tick)
  );

  assign mask = axis_mask(variant_sel);

  // ****************************************
  // operation cycle overrun
  // ****************************************
  logic [AMSF_TIME_W-1:0] busy_cnt_q;
  logic [AMSF_TIME_W-1:0] busy_cnt_d;
  logic busy_q;
  logic busy_d;
  logic overrun_q;
  logic overrun_d;

  always_comb begin
    busy_d = busy_q;
    busy_cnt_d = busy_cnt_q;
    if (motion_start) begin
      busy_d = 1'b1;
      busy_cnt_d = AMSF_TIME_ZERO;
    end else if (motion_done) begin
      busy_d = 1'b0;
    end else if (busy_q && busy_cnt_q != '1) begin
      busy_cnt_d = AMSF_TIME_W'(busy_cnt_q + 1'b1);
    end
    overrun_d = overrun_q;
    // set wins over a same-cycle program reset
    if (user_reset) begin
      overrun_d = AMSF_FLAG_RST;
    end
    if (busy_q && busy_cnt_q >= operation_cycle_setting) begin
      overrun_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      busy_cnt_q <= AMSF_TIME_ZERO;
      overrun_q <= AMSF_FLAG_RST;
    end else begin
      busy_q <= busy_d;
      busy_cnt_q <= busy_cnt_d;
      overrun_q <= overrun_d;
    end
  end

  assign cycle_overrun_flag = overrun_q;

  // ****************************************
  // per-axis flags
  // ****************************************
  // every group below moves only on the operation cycle tick
  // a stop-type decel already seen blocks a zero request; auto decel only outside follow-up
  function automatic logic zero_refused(input logic jog, input logic stop,
                                        input amsf_dec_t dec, input logic fup);
    return jog || stop || (dec == AMSF_DEC_OTHER) || (dec == AMSF_DEC_AUTO && !fup);
  endfunction

  // ****************************************
  // speed change accepting
  // ****************************************
  logic [31:0] spd_q;
  logic [31:0] spd_d;

  always_comb begin
    spd_d = spd_q;
    if (tick) begin
      for (int i = 0; i < AMSF_AXES_MAX; i++) begin
        if (speed_change_req[i]) begin
          spd_d[i] = 1'b1;
        end else if (speed_change_done[i]) begin
          spd_d[i] = 1'b0;
        end
      end
      spd_d = spd_d & mask;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      spd_q <= '0;
    end else begin
      spd_q <= spd_d;
    end
  end

  // ****************************************
  // automatic decelerating
  // ****************************************
  logic [31:0] adec_q;
  logic [31:0] adec_d;

  always_comb begin
    adec_d = adec_q;
    if (tick) begin
      for (int i = 0; i < AMSF_AXES_MAX; i++) begin
        // s-curve may report decel early, so no accel check
        if (auto_decel_active[i] && !zero_travel[i]) begin
          adec_d[i] = 1'b1;
        end
        if (followup_mode[i] && followup_addr_change[i]) begin
          adec_d[i] = 1'b0;
        end else if (start_complete[i] && !jog_decel[i] && !mpg_active[i]
                     && !stop_decel[i] && !zero_travel[i]) begin
          adec_d[i] = 1'b0;
        end
      end
      adec_d = adec_d & mask;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      adec_q <= '0;
    end else begin
      adec_q <= adec_d;
    end
  end

  // ****************************************
  // zero-speed accepting
  // ****************************************
  logic [31:0] zero_q;
  logic [31:0] zero_d;
  logic [31:0] hold_q;
  logic [31:0] hold_d;
  logic [31:0] interp_zero;
  amsf_dec_t dec_q [AMSF_AXES_MAX];
  amsf_dec_t dec_d [AMSF_AXES_MAX];

  always_comb begin
    zero_d = zero_q;
    hold_d = hold_q;
    dec_d = dec_q;
    interp_zero = '0;
    if (tick) begin
      for (int i = 0; i < AMSF_AXES_MAX; i++) begin
        // remember which kind of decel the axis is in
        if (auto_decel_active[i] && !zero_travel[i]) begin
          dec_d[i] = AMSF_DEC_AUTO;
        end else if (jog_decel[i] || stop_decel[i]) begin
          dec_d[i] = AMSF_DEC_OTHER;
        end
        if (stop_cause[i] || stop_complete[i]) begin
          zero_d[i] = 1'b0;
          dec_d[i] = AMSF_DEC_OTHER;
        end else if (speed_change_req[i] && speed_change_zero[i]) begin
          if (start_accept_flags[i]
              && !zero_refused(jog_decel[i], stop_decel[i], dec_q[i], followup_mode[i])) begin
            zero_d[i] = 1'b1;
            dec_d[i] = AMSF_DEC_SPEED0;
          end
        end else if (speed_change_req[i]) begin
          zero_d[i] = 1'b0;
          dec_d[i] = AMSF_DEC_NONE;
        end
      end
      // spread only once every axis has decided, so axis order adds no tick of lag
      interp_zero = interp_axes & speed_change_req & speed_change_zero & zero_d;
      for (int i = 0; i < AMSF_AXES_MAX; i++) begin
        if (interp_axes[i] && (interp_zero != '0) && !stop_cause[i] && !stop_complete[i]
            && !speed_change_req[i]) begin
          zero_d[i] = 1'b1;
        end
        if (!start_accept_flags[i] && !zero_d[i]) begin
          dec_d[i] = AMSF_DEC_NONE;
        end
        // keep zero-speed flag while stopped with start accept held
        if (zero_q[i] && start_accept_flags[i] && !stop_cause[i] && !stop_complete[i]
            && !speed_change_req[i]) begin
          zero_d[i] = 1'b1;
        end
        // a follow-up address change must not restart an axis held at zero speed
        hold_d[i] = zero_d[i];
      end
      zero_d = zero_d & mask;
      hold_d = hold_d & mask;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      zero_q <= '0;
      hold_q <= '0;
      for (int i = 0; i < AMSF_AXES_MAX; i++) begin
        dec_q[i] <= AMSF_DEC_NONE;
      end
    end else begin
      zero_q <= zero_d;
      hold_q <= hold_d;
      dec_q <= dec_d;
    end
  end

  // ****************************************
  // control loop monitor
  // ****************************************
  logic [31:0] loop_q;
  logic [31:0] loop_d;

  always_comb begin
    loop_d = loop_q;
    if (tick) begin
      loop_d = loop_change_cmd & mask;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      loop_q <= '0;
    end else begin
      loop_q <= loop_d;
    end
  end

  assign speed_change_accepting_flags = spd_q;
  assign auto_decelerating_flags = adec_q;
  assign zero_speed_accepting_flags = zero_q;
  assign loop_monitor_flags = loop_q;
  assign restart_block = hold_q;
endmodule

// [amsf_pkg.sv]
package amsf_pkg;
  // axis counts per variant
  localparam int AMSF_AXES_MAX = 32;
  localparam int AMSF_AXES_MID = 16;
  localparam int AMSF_AXES_MIN = 8;
  localparam logic [1:0] AMSF_VAR_32 = 2'h0;
  localparam logic [1:0] AMSF_VAR_16 = 2'h1;
  localparam logic [1:0] AMSF_VAR_8 = 2'h2;
  // width of the motion processing time and cycle length counters
  localparam int AMSF_TIME_W = 16;
  localparam logic [15:0] AMSF_TIME_ZERO = 16'h0000;
  localparam logic AMSF_FLAG_RST = 1'b0;
  // operation cycle tick: 1 us at 200 MHz
  localparam int AMSF_CLK_MHZ = 200;
  localparam int AMSF_OP_CYCLE_US = 1;
  localparam int AMSF_OP_CYCLE_CLKS = AMSF_OP_CYCLE_US * AMSF_CLK_MHZ;
  localparam logic [15:0] AMSF_OP_CYCLE_LAST = 16'(AMSF_OP_CYCLE_CLKS - 1);
  // decel cause kept per axis
  typedef enum logic [1:0] {
    AMSF_DEC_NONE,
    AMSF_DEC_AUTO,
    AMSF_DEC_SPEED0,
    AMSF_DEC_OTHER
  } amsf_dec_t;
endpackage

// [amsf_tick.sv]
`timescale 1ns/1ps
module amsf_tick
  import amsf_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // operation cycle enable
  output logic tick
);
  logic [AMSF_TIME_W-1:0] cnt_q;
  logic [AMSF_TIME_W-1:0] cnt_d;
  logic tick_d;
  logic tick_q;

  always_comb begin
    tick_d = (cnt_q == AMSF_OP_CYCLE_LAST);
    cnt_d = tick_d ? AMSF_TIME_ZERO : AMSF_TIME_W'(cnt_q + 1'b1);
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= AMSF_TIME_ZERO;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule

// [amsf_servo_model.sv]
`timescale 1ns/1ps
module amsf_servo_model (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [31:0] go,
  output logic [31:0] decel,
  output logic [31:0] done
);
  logic [11:0] cnt_q, cnt_d;
  // one shared move timer: axes handed a move together run in lockstep
  always_comb cnt_d = (|go) ? cnt_q + {11'h0, cnt_q != 12'hFFF} : 12'h000;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) cnt_q <= 12'h000;
    else cnt_q <= cnt_d;
  end
  assign decel = go & {32{cnt_q >= 12'h12C && cnt_q < 12'h2BC}};
  assign done = go & {32{cnt_q >= 12'h2BC}};
endmodule

// [amsf_status_monitor.sv]
`timescale 1ns/1ps
module amsf_status_monitor
  import amsf_pkg::*;
(
  input wire logic sys_clk, sys_rst, user_reset, motion_start, motion_done,
  input wire logic [1:0] variant_sel,
  input wire logic [15:0] operation_cycle_setting,
  input wire logic [31:0] start_accept_flags, speed_change_req, jog_decel, stop_decel,
  input wire logic [31:0] stop_cause, auto_decel_active, zero_travel, mpg_active,
  input wire logic [31:0] loop_change_cmd, speed_change_accepting_flags,
  input wire logic [31:0] auto_decelerating_flags, zero_speed_accepting_flags,
  input wire logic [31:0] loop_monitor_flags,
  input wire logic cycle_overrun_flag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_ovr_set: assert property (
    (operation_cycle_setting == 16'h0004 && motion_start) ##1 !motion_done [*6]
    |-> ##[0:2] cycle_overrun_flag) else $error("overrun missed");
  a_ovr_hold: assert property (
    cycle_overrun_flag && !user_reset |=> cycle_overrun_flag) else $error("overrun lost");
  a_spd_cause: assert property (
    $rose(speed_change_accepting_flags[0]) |-> $past(speed_change_req[0]))
    else $error("speed flag no cause");
  a_mask_mid: assert property (
    $changed(loop_monitor_flags) && variant_sel == AMSF_VAR_16
    |-> loop_monitor_flags[31:16] == 16'h0000) else $error("axis mask");
  a_dec_cause: assert property (
    $rose(auto_decelerating_flags[0])
    |-> $past(auto_decel_active[0]) && !$past(zero_travel[0])) else $error("decel no cause");
  a_dec_keep: assert property (
    $fell(auto_decelerating_flags[0])
    |-> !$past(jog_decel[0] | mpg_active[0] | stop_decel[0])) else $error("decel cleared");
  a_zero_ok: assert property (
    (zero_speed_accepting_flags & ~$past(zero_speed_accepting_flags) & ($past(jog_decel)
    | $past(stop_decel) | ~$past(start_accept_flags))) == 32'h0) else $error("zero refused");
  a_zero_stop: assert property (
    $rose(zero_speed_accepting_flags[0]) |-> !$past(stop_cause[0])) else $error("zero stop");
  a_loop_copy: assert property (
    $changed(loop_monitor_flags[0]) |-> loop_monitor_flags[0] == $past(loop_change_cmd[0]))
    else $error("loop copy");
  c_ovr: cover property ($rose(cycle_overrun_flag));
  c_zero: cover property ($rose(zero_speed_accepting_flags[0]));
  c_dec: cover property ($fell(auto_decelerating_flags[0]));
endmodule
bind amsf_status amsf_status_monitor mon (.*);

// [amsf_status_tb.sv]
`timescale 1ns/1ps
module amsf_status_tb;
  import amsf_pkg::*;
  logic sys_clk, sys_rst, user_reset, motion_start, motion_done, cycle_overrun_flag;
  logic [1:0] variant_sel;
  logic [15:0] operation_cycle_setting;
  logic [31:0] start_accept_flags, speed_change_req, speed_change_zero, speed_change_done;
  logic [31:0] interp_axes, auto_decel_active, followup_mode, followup_addr_change;
  logic [31:0] start_complete, jog_decel, mpg_active, stop_decel, stop_cause, stop_complete;
  logic [31:0] zero_travel, loop_change_cmd, go, restart_block;
  logic [31:0] speed_change_accepting_flags, auto_decelerating_flags;
  logic [31:0] zero_speed_accepting_flags, loop_monitor_flags;
  int err_count, n_compared;
  amsf_status uut (.*);
  amsf_servo_model servo (.sys_clk, .sys_rst, .go, .decel(auto_decel_active),
    .done(start_complete));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // processing span of n clocks between start and done pulses
  task automatic ovr(input int n);
    motion_start <= 1'b1;
    w(1);
    motion_start <= 1'b0;
    w(n);
    motion_done <= 1'b1;
    w(1);
    motion_done <= 1'b0;
    w(4);
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #100us;
    err_count++;
    close_out();
  end
  initial begin
    err_count = 0;
    n_compared = 0;
    {user_reset, motion_start, motion_done} = 3'h0;
    variant_sel = AMSF_VAR_32;
    operation_cycle_setting = 16'h0004;
    {start_accept_flags, speed_change_req, speed_change_zero, speed_change_done} = 128'h0;
    {interp_axes, followup_mode, followup_addr_change, jog_decel, mpg_active} = 160'h0;
    {stop_decel, stop_cause, stop_complete, zero_travel, loop_change_cmd, go} = 192'h0;
    sys_rst = 1'b1;
    w(12);
    sys_rst <= 1'b0;
    w(2);
    chk(zero_speed_accepting_flags | auto_decelerating_flags, 32'h0);
    ovr(1);
    chk({31'h0, cycle_overrun_flag}, 32'h0);
    ovr(8);
    chk({31'h0, cycle_overrun_flag}, 32'h1);
    w(50);
    chk({31'h0, cycle_overrun_flag}, 32'h1);
    user_reset <= 1'b1;
    w(1);
    user_reset <= 1'b0;
    w(3);
    chk({31'h0, cycle_overrun_flag}, 32'h0);
    loop_change_cmd <= 32'hA5A5A5A5;
    start_accept_flags <= 32'h0000000F;
    speed_change_req <= 32'h00000001;
    w(420);
    chk(loop_monitor_flags, 32'hA5A5A5A5);
    chk(speed_change_accepting_flags & 32'h1, 32'h1);
    jog_decel <= 32'h4;
    stop_decel <= 32'h8;
    speed_change_req <= 32'hD;
    speed_change_zero <= 32'hC;
    w(420);
    chk(zero_speed_accepting_flags & 32'hC, 32'h0);
    interp_axes <= 32'h3;
    speed_change_zero <= 32'hD;
    w(420);
    chk(zero_speed_accepting_flags & 32'h3, 32'h3);
    chk(restart_block & 32'h3, 32'h3);
    speed_change_zero <= 32'h0;
    w(420);
    chk(zero_speed_accepting_flags & 32'h3, 32'h2);
    speed_change_req <= 32'h0;
    speed_change_zero <= 32'h0;
    stop_cause <= 32'h3;
    w(420);
    chk(zero_speed_accepting_flags & 32'h3, 32'h0);
    {stop_cause, jog_decel, stop_decel} <= 96'h0;
    go <= 32'h1;
    w(520);
    chk(auto_decelerating_flags & 32'h1, 32'h1);
    mpg_active <= 32'h1;
    w(500);
    chk(auto_decelerating_flags & 32'h1, 32'h1);
    mpg_active <= 32'h0;
    w(420);
    chk(auto_decelerating_flags & 32'h1, 32'h0);
    go <= 32'h0;
    variant_sel <= AMSF_VAR_16;
    w(420);
    chk(loop_monitor_flags, 32'h0000A5A5);
    close_out();
  end
endmodule
